// ===== pkg/smul_map.svh
/*
  Address map, field positions, reset values and timing counts of the
  shift-and-add multiplier.
  Assumes a 32-bit APB with byte address = register index * 4.
*/
`ifndef SMUL_MAP_SVH
`define SMUL_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is index * 4)
// ----------------------------------------------------------------------
`define SMUL_IDX_PRODUCT   16'hffd0
`define SMUL_IDX_CONTROL   16'hffd2
`define SMUL_IDX_OPERAND_A 16'hffd4
`define SMUL_IDX_OPERAND_B 16'hffd5
`define SMUL_IDX_BIT_WRITE 16'hffd6
`define SMUL_ADDR_W        18
`define SMUL_IDX_LO        2

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define SMUL_RUN_POS       0
`define SMUL_CTRL_RESET    1'h0
`define SMUL_LANE_LO       0
`define SMUL_LANE_HI       1
`define SMUL_BYTE_W        8
`define SMUL_BW_BIT_LO     0
`define SMUL_BW_BIT_HI     2
`define SMUL_BW_VALUE      3
`define SMUL_BW_SELECT_B   4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SMUL_RUN_CYCLES    5'h10
`define SMUL_ELAPSED_MAX   5'h1f

`endif

// ===== pkg/smul_pkg.sv
/*
  Types shared by the multiplier files.
  Assumes smul_map.svh is on the include path.
*/
`include "smul_map.svh"

package smul_pkg;

  typedef enum logic {SMUL_MASTER, SMUL_SLAVE} smul_stage_type;

  typedef enum logic [2:0] {
    SMUL_REG_NONE,
    SMUL_REG_PRODUCT,
    SMUL_REG_CONTROL,
    SMUL_REG_OPERAND_A,
    SMUL_REG_OPERAND_B,
    SMUL_REG_BIT_WRITE
  } smul_reg_type;

  // Maps a word-aligned byte address to the register it selects
  function automatic smul_reg_type smul_decode(input logic [`SMUL_ADDR_W-1:0] addr);
    logic [`SMUL_ADDR_W-`SMUL_IDX_LO-1:0] idx;
    idx = addr[`SMUL_ADDR_W-1:`SMUL_IDX_LO];
    if (addr[`SMUL_IDX_LO-1:0] != '0) return SMUL_REG_NONE;
    unique case (idx)
      `SMUL_IDX_PRODUCT:   return SMUL_REG_PRODUCT;
      `SMUL_IDX_CONTROL:   return SMUL_REG_CONTROL;
      `SMUL_IDX_OPERAND_A: return SMUL_REG_OPERAND_A;
      `SMUL_IDX_OPERAND_B: return SMUL_REG_OPERAND_B;
      `SMUL_IDX_BIT_WRITE: return SMUL_REG_BIT_WRITE;
      default:             return SMUL_REG_NONE;
    endcase
  endfunction

endpackage

// ===== core/smul_rst_sync.sv
/*
  Two-stage release synchroniser for the active-low reset.
  Assumes reset_n may change at any time relative to sys_clk.
*/
`timescale 1ns/1ns

module smul_rst_sync
  import smul_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  output logic      rst_n_sync
);

  logic meta_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r     <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      meta_r     <= 1'b1;
      rst_n_sync <= meta_r;
    end
  end

endmodule

// ===== core/smul_step.sv
/*
  Selector and adder of one shift-and-add step.
  Assumes the caller registers the sum.
*/
`timescale 1ns/1ns

module smul_step
  import smul_pkg::*;
#(
  parameter int OP_W = 8
)
(
  input  wire logic [OP_W-1:0]         operand_a,
  input  wire logic [OP_W-1:0]         operand_b,
  input  wire logic [$clog2(OP_W)-1:0] step,
  input  wire logic [2*OP_W-1:0]       acc,
  output logic      [2*OP_W-1:0]       sum
);

  logic [2*OP_W-1:0] selected;

  // Shifted first operand when the matching bit of the second is set
  always_comb begin
    selected = '0;
    if (operand_b[step]) begin
      selected = {{OP_W{1'b0}}, operand_a} << step;
    end
    sum = acc + selected;
  end

endmodule

// ===== core/smul_top.sv
/*
  APB-mapped 8 x 8 shift-and-add multiplier with a 16-bit product.
  Assumes an APB master on sys_clk; reset_n is asynchronous.
*/
`timescale 1ns/1ns
`include "smul_map.svh"

module smul_top
  import smul_pkg::*;
#(
  parameter int OP_W = 8
)
(
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`SMUL_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr
);

  localparam int CNT_W  = $clog2(OP_W);
  localparam int PROD_W = 2 * OP_W;

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (OP_W != 2 * `SMUL_BYTE_W / 2) begin : g_bad_width
    $error("OP_W must be 8 so that the product fills both byte lanes");
  end

  logic                  rst_n_sync;
  logic                  run_r;
  logic                  done_r;
  logic [CNT_W-1:0]      count_r;
  smul_stage_type        stage_r;
  logic [PROD_W-1:0]     product_r;
  logic [PROD_W-1:0]     step_sum;
  logic [OP_W-1:0]       operand_a_r;
  logic [OP_W-1:0]       operand_b_r;
  logic [31:0]           prdata_r;
  smul_reg_type          reg_sel;
  logic                  setup;
  logic                  access;
  logic                  wr;
  logic                  wr_ctrl;
  logic                  start_wr;
  logic                  stop_wr;
  logic                  add_now;
  logic [31:0]           read_word;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  smul_rst_sync u_rst_sync (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .rst_n_sync (rst_n_sync)
  );

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign reg_sel  = smul_decode(paddr);
  assign wr       = access & pwrite;
  assign wr_ctrl  = wr && reg_sel == SMUL_REG_CONTROL && pstrb[`SMUL_LANE_LO];
  assign start_wr = wr_ctrl & pwdata[`SMUL_RUN_POS] & ~run_r;
  assign stop_wr  = wr_ctrl & ~pwdata[`SMUL_RUN_POS];
  assign pready   = access;
  assign pslverr  = access && reg_sel == SMUL_REG_NONE;
  assign prdata   = prdata_r;

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      run_r <= `SMUL_CTRL_RESET;
    end else if (wr_ctrl) begin
      run_r <= pwdata[`SMUL_RUN_POS];
    end
  end

  // ----------------------------------------------------------------------
  // Step counter and master/slave stage
  // ----------------------------------------------------------------------
  assign add_now = run_r && !stop_wr && !done_r && stage_r == SMUL_SLAVE;

  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      count_r <= '0;
      stage_r <= SMUL_MASTER;
      done_r  <= 1'b0;
    end else if (!run_r || stop_wr) begin
      count_r <= '0;
      stage_r <= SMUL_MASTER;
      done_r  <= 1'b0;
    end else if (!done_r) begin
      unique case (stage_r)
        SMUL_MASTER: begin
          stage_r <= SMUL_SLAVE;
        end
        SMUL_SLAVE: begin
          stage_r <= SMUL_MASTER;
          if (count_r == CNT_W'(OP_W - 1)) begin
            done_r <= 1'b1;
          end else begin
            count_r <= count_r + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Product register
  // ----------------------------------------------------------------------
  smul_step #(
    .OP_W (OP_W)
  ) u_step (
    .operand_a (operand_a_r),
    .operand_b (operand_b_r),
    .step      (count_r),
    .acc       (product_r),
    .sum       (step_sum)
  );

  // No reset: contents are undefined until written or computed
  always_ff @(posedge sys_clk) begin
    if (start_wr) begin
      product_r <= '0;
    end else if (add_now) begin
      product_r <= step_sum;
    end else if (wr && reg_sel == SMUL_REG_PRODUCT) begin
      if (pstrb[`SMUL_LANE_LO]) begin
        product_r[`SMUL_BYTE_W-1:0] <= pwdata[`SMUL_BYTE_W-1:0];
      end
      if (pstrb[`SMUL_LANE_HI]) begin
        product_r[PROD_W-1:`SMUL_BYTE_W] <= pwdata[PROD_W-1:`SMUL_BYTE_W];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Operand registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (wr && reg_sel == SMUL_REG_OPERAND_A && pstrb[`SMUL_LANE_LO]) begin
      operand_a_r <= pwdata[OP_W-1:0];
    end else if (wr && reg_sel == SMUL_REG_BIT_WRITE && pstrb[`SMUL_LANE_LO]
                 && !pwdata[`SMUL_BW_SELECT_B]) begin
      operand_a_r[pwdata[`SMUL_BW_BIT_LO +: CNT_W]] <= pwdata[`SMUL_BW_VALUE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr && reg_sel == SMUL_REG_OPERAND_B && pstrb[`SMUL_LANE_LO]) begin
      operand_b_r <= pwdata[OP_W-1:0];
    end else if (wr && reg_sel == SMUL_REG_BIT_WRITE && pstrb[`SMUL_LANE_LO]
                 && pwdata[`SMUL_BW_SELECT_B]) begin
      operand_b_r[pwdata[`SMUL_BW_BIT_LO +: CNT_W]] <= pwdata[`SMUL_BW_VALUE];
    end
  end

  // ----------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------------
  always_comb begin
    read_word = '0;
    unique case (reg_sel)
      SMUL_REG_PRODUCT:   read_word[PROD_W-1:0] = product_r;
      SMUL_REG_CONTROL:   read_word[`SMUL_RUN_POS] = run_r;
      SMUL_REG_OPERAND_A: read_word[OP_W-1:0] = operand_a_r;
      SMUL_REG_OPERAND_B: read_word[OP_W-1:0] = operand_b_r;
      SMUL_REG_BIT_WRITE: read_word = '0;
      SMUL_REG_NONE:      read_word = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      prdata_r <= '0;
    end else if (setup && !pwrite) begin
      prdata_r <= read_word;
    end
  end

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  logic [4:0]        elapsed_r;
  logic [PROD_W-1:0] expect_r;
  logic              ops_touched_r;

  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      elapsed_r <= '0;
    end else if (!run_r || stop_wr) begin
      elapsed_r <= '0;
    end else if (elapsed_r != `SMUL_ELAPSED_MAX) begin
      elapsed_r <= elapsed_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      expect_r      <= '0;
      ops_touched_r <= 1'b1;
    end else if (start_wr) begin
      expect_r      <= PROD_W'(operand_a_r) * PROD_W'(operand_b_r);
      ops_touched_r <= 1'b0;
    end else if (wr && (reg_sel == SMUL_REG_OPERAND_A || reg_sel == SMUL_REG_OPERAND_B
                        || reg_sel == SMUL_REG_BIT_WRITE || reg_sel == SMUL_REG_PRODUCT)) begin
      ops_touched_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_sync);

  sequence s_run_begins;
    $rose(run_r) ##0 !stop_wr;
  endsequence

  sequence s_first_step;
    ##2 (count_r == CNT_W'(1) || !run_r);
  endsequence

  AST_PRODUCT_VALUE: assert property (
    $rose(done_r) && !ops_touched_r |-> product_r == expect_r
  ) else $error("Product differs from operand A times operand B");

  AST_DONE_AT_16: assert property (
    run_r && !stop_wr |-> done_r == (elapsed_r >= `SMUL_RUN_CYCLES)
  ) else $error("Completion not reached exactly 16 clocks after start");

  AST_PRODUCT_BYTE: assert property (
    wr && reg_sel == SMUL_REG_PRODUCT && pstrb[1:0] == 2'h2 && !add_now && !start_wr
    |=> product_r[`SMUL_BYTE_W-1:0] == $past(product_r[`SMUL_BYTE_W-1:0])
        && product_r[PROD_W-1:`SMUL_BYTE_W] == $past(pwdata[PROD_W-1:`SMUL_BYTE_W])
  ) else $error("Product high byte write disturbed the low byte");

  AST_OPERAND_BIT: assert property (
    wr && reg_sel == SMUL_REG_BIT_WRITE && pstrb[`SMUL_LANE_LO] && !pwdata[`SMUL_BW_SELECT_B]
    |=> operand_a_r[$past(pwdata[`SMUL_BW_BIT_LO +: CNT_W])] == $past(pwdata[`SMUL_BW_VALUE])
  ) else $error("Single-bit operand write not applied");

  AST_CTRL_RESET: assert property (
    $rose(rst_n_sync) |-> !run_r && count_r == '0
  ) else $error("Control not cleared by reset");

  AST_STOP_CLEARS: assert property (
    stop_wr |=> !run_r && count_r == '0 && !done_r
  ) else $error("Stop did not clear the counter");

  AST_STATUS_READ: assert property (
    setup && !pwrite && reg_sel == SMUL_REG_CONTROL
    |=> prdata[`SMUL_RUN_POS] == $past(run_r) && prdata[31:1] == '0
  ) else $error("Run status read wrong");

  AST_COUNT_BEGINS: assert property (
    s_run_begins |-> s_first_step
  ) else $error("Counter did not start stepping");

  AST_STEP_ADD: assert property (
    add_now && count_r != CNT_W'(OP_W - 1)
    |=> count_r == $past(count_r) + 1'b1 && product_r == $past(step_sum)
  ) else $error("Step did not add and advance");

  AST_STOP_KEEPS: assert property (
    done_r && stop_wr |=> (product_r == $past(product_r)) [*2]
  ) else $error("Product lost after stop at final count");

  AST_IDLE_CLEAR: assert property (
    !run_r |-> count_r == '0 && stage_r == SMUL_MASTER && !done_r
  ) else $error("Counter or slave stage not cleared while stopped");

endmodule

// ===== dv/shift_add_multiplier_8x8_bench.sv
/*
  Self-checking bench for the APB-mapped shift-and-add multiplier.
  Assumes smul_map.svh on the include path and smul_pkg compiled first.
*/
`timescale 1ns/1ns
`include "smul_map.svh"

module shift_add_multiplier_8x8_bench
  import smul_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and design instance
  // ----------------------------------------------------------------------
  localparam logic [17:0] ADDR_PROD = {`SMUL_IDX_PRODUCT, 2'b00};
  localparam logic [17:0] ADDR_CTRL = {`SMUL_IDX_CONTROL, 2'b00};
  localparam logic [17:0] ADDR_OPA  = {`SMUL_IDX_OPERAND_A, 2'b00};
  localparam logic [17:0] ADDR_OPB  = {`SMUL_IDX_OPERAND_B, 2'b00};
  localparam logic [17:0] ADDR_BITW = {`SMUL_IDX_BIT_WRITE, 2'b00};
  localparam logic [17:0] ADDR_HOLE = {16'hffd1, 2'b00};
  localparam int          LIMIT     = 20000;

  logic        sys_clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        last_err;
  logic [31:0] rd_val;
  int          n_errors;
  int          check_count;
  int          cycles;
  logic [7:0]  tab_a [4] = '{8'haa, 8'hff, 8'h00, 8'h01};
  logic [7:0]  tab_b [4] = '{8'hd3, 8'hff, 8'h5a, 8'h80};

  smul_top #(.OP_W(8)) uut (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // ----------------------------------------------------------------------
  // Clock, timeout and report
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    cycles = 0;
    forever begin
      @(posedge sys_clk);
      cycles++;
      if (cycles >= LIMIT) begin
        $display("mismatch timeout expected done seen hang");
        n_errors++;
        wrap_up();
      end
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------------
  // APB master tasks
  // ----------------------------------------------------------------------
  task automatic apb_xfer(input logic wr, input logic [17:0] addr, input logic [31:0] wdata,
                          input logic [3:0] strb, output logic [31:0] rdata);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    pstrb   <= strb;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdata    = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [17:0] addr, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] unused;
    apb_xfer(1'b1, addr, data, strb, unused);
  endtask

  task automatic rd(input logic [17:0] addr, output logic [31:0] data);
    apb_xfer(1'b0, addr, 32'h0000_0000, 4'h0, data);
  endtask

  // ----------------------------------------------------------------------
  // Multiply sequences
  // ----------------------------------------------------------------------
  task automatic run_and_check(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] exp;
    exp = 16'(a) * 16'(b);
    wr(ADDR_CTRL, 32'h0000_0001, 4'h1);
    repeat (16) @(posedge sys_clk);
    rd(ADDR_PROD, rd_val);
    check("product", rd_val, {16'h0000, exp});
    rd(ADDR_CTRL, rd_val);
    check("run_bit busy", rd_val, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0000, 4'h1);
    rd(ADDR_CTRL, rd_val);
    check("run_bit stopped", rd_val, 32'h0000_0000);
    rd(ADDR_PROD, rd_val);
    check("product held", rd_val, {16'h0000, exp});
  endtask

  task automatic set_ops(input logic [7:0] a, input logic [7:0] b);
    wr(ADDR_OPA, {24'h000000, a}, 4'h1);
    wr(ADDR_OPB, {24'h000000, b}, 4'h1);
    rd(ADDR_OPA, rd_val);
    check("operand_a", rd_val, {24'h000000, a});
    rd(ADDR_OPB, rd_val);
    check("operand_b", rd_val, {24'h000000, b});
  endtask

  task automatic bit_write(input logic sel_b, input logic val, input logic [2:0] idx);
    wr(ADDR_BITW, {27'h0000000, sel_b, val, idx}, 4'h1);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_n     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    pstrb       = '0;
    n_errors    = 0;
    check_count = 0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(ADDR_CTRL, rd_val);
    check("control reset", rd_val, 32'h0000_0000);
    check("mapped slverr", {31'h0, last_err}, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0001, 4'h0);
    rd(ADDR_CTRL, rd_val);
    check("control no strobe", rd_val, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      set_ops(tab_a[i], tab_b[i]);
      run_and_check(tab_a[i], tab_b[i]);
    end
    set_ops(8'h00, 8'hff);
    bit_write(1'b0, 1'b1, 3'd7);
    bit_write(1'b0, 1'b1, 3'd1);
    bit_write(1'b1, 1'b0, 3'd0);
    rd(ADDR_OPA, rd_val);
    check("operand_a bit", rd_val, 32'h0000_0082);
    rd(ADDR_OPB, rd_val);
    check("operand_b bit", rd_val, 32'h0000_00fe);
    run_and_check(8'h82, 8'hfe);
    set_ops(8'h5b, 8'hc7);
    wr(ADDR_CTRL, 32'h0000_0001, 4'h1);
    repeat (5) @(posedge sys_clk);
    wr(ADDR_CTRL, 32'h0000_0000, 4'h1);
    rd(ADDR_CTRL, rd_val);
    check("run_bit aborted", rd_val, 32'h0000_0000);
    repeat (4) @(posedge sys_clk);
    run_and_check(8'h5b, 8'hc7);
    wr(ADDR_PROD, 32'h0000_5634, 4'h1);
    wr(ADDR_PROD, 32'h0000_12ff, 4'h2);
    rd(ADDR_PROD, rd_val);
    check("product bytes", rd_val, 32'h0000_1234);
    wr(ADDR_PROD, 32'hffff_abcd, 4'hf);
    rd(ADDR_PROD, rd_val);
    check("product word", rd_val, 32'h0000_abcd);
    rd(ADDR_HOLE, rd_val);
    check("hole data", rd_val, 32'h0000_0000);
    check("hole slverr", {31'h0, last_err}, 32'h0000_0001);
    rd(ADDR_CTRL | 18'h2, rd_val);
    check("misaligned slverr", {31'h0, last_err}, 32'h0000_0001);
    wrap_up();
  end

endmodule
